// ==== verilog/burst4_sram_device.sv ====
/*
 sram port end: takes read and write bursts of four beats from the pin bundle,
 stores them in flip-flop memory and returns read bursts with echo clocks.
 assumes the controller obeys command spacing and drives the clock pair from
 the same system clock, so no pin synchronisers are needed.
*/
// Overview of operation
// - controller waits 2048 clocks for lock
// - controller holds dll off low 5 ns
// - static clock 30 ns resets the dll
// - read returns four beats from burst counter
// - write takes one address, four beats
// - outputs float one cycle after idle
// - per-beat active-low byte write enables
// - read of pending write returns new data
// - controller drives active-low selects, enables
`timescale 1ns/1ps
`default_nettype none
module burst4_sram_device
    import burst4_sram_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 36
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    burst4_sram_if.dev bus,
    output logic o_dll_locked
);
    localparam int NBYTE = DATA_W / BYTE_W;
    localparam int MEM_N = (2 ** ADDR_W) * BURST_LEN;
    localparam int STATIC_W = $clog2(STATIC_CYCLES + 1);
    localparam logic [STATIC_W-1:0] STATIC_MAX = STATIC_W'(STATIC_CYCLES);
    localparam logic [LOCK_CNT_W-1:0] LOCK_MAX = LOCK_CNT_W'(DLL_LOCK_TIME_CYCLES);

    typedef struct packed {
        logic k_prev;
        logic kn_prev;
        logic [STATIC_W-1:0] static_cnt;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic cmd_busy;
        logic [1:0] rd_v;
        logic [1:0][ADDR_W-1:0] rd_a;
        logic [1:0][3:0] rd_c;
        logic rd_sel;
        logic [1:0] wr_v;
        logic [1:0][ADDR_W-1:0] wr_a;
        logic [1:0][3:0] wr_c;
        logic wr_sel;
        logic [DATA_W-1:0] q;
        logic q_oe;
        logic rd_valid;
        logic echo_clk;
        logic echo_clk_n;
        logic [MEM_N-1:0][DATA_W-1:0] mem;
    } dev_state_s;

    dev_state_s st;
    dev_state_s next_st;
    logic k_rise;
    logic kn_rise;
    logic edge_seen;

    // burst counter: linear order within the four-word block
    function automatic logic [ADDR_W+1:0] word_index(input logic [ADDR_W-1:0] a, input logic [3:0] beat);
        word_index = {a, beat[1:0]};
    endfunction

    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [NBYTE-1:0] en_n
    );
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int b = 0; b < NBYTE; b++)
        begin
            if (!en_n[b])
            begin
                res[b*BYTE_W +: BYTE_W] = new_word[b*BYTE_W +: BYTE_W];
            end
        end
        merge_bytes = res;
    endfunction

    always_comb
    begin
        logic [3:0] c;
        logic [ADDR_W+1:0] idx;
        c = 4'h0;
        idx = '0;
        next_st = st;
        k_rise = bus.k & ~st.k_prev;
        kn_rise = bus.k_n & ~st.kn_prev;
        edge_seen = k_rise | kn_rise;
        next_st.k_prev = bus.k;
        next_st.kn_prev = bus.k_n;
        // echo clocks registered with the data so they stay aligned
        next_st.echo_clk = bus.k;
        next_st.echo_clk_n = bus.k_n;

        if (bus.k != st.k_prev)
        begin
            // a new level has already stood for this cycle
            next_st.static_cnt = STATIC_W'(1);
        end
        else if (st.static_cnt != STATIC_MAX)
        begin
            next_st.static_cnt = st.static_cnt + STATIC_W'(1);
        end
        // relock needed after a stopped clock or a dll off pulse
        if ((next_st.static_cnt == STATIC_MAX) || !bus.doff_n)
        begin
            next_st.lock_cnt = '0;
        end
        else if (k_rise && (st.lock_cnt != LOCK_MAX))
        begin
            next_st.lock_cnt = st.lock_cnt + LOCK_CNT_W'(1);
        end

        if (edge_seen)
        begin
            // no beat on this edge means the bus floats
            next_st.q_oe = 1'b0;
            next_st.rd_valid = 1'b0;
            for (int i = 0; i < 2; i++)
            begin
                if (st.wr_v[i])
                begin
                    c = st.wr_c[i] + 4'h1;
                    next_st.wr_c[i] = c;
                    // beats land on edges two to five
                    if ((c >= WR_FIRST_EDGE) && (c <= WR_LAST_EDGE))
                    begin
                        // four beats to the four burst words
                        idx = word_index(st.wr_a[i], c - WR_FIRST_EDGE);
                        // only enabled bytes of this beat
                        next_st.mem[idx] = merge_bytes(st.mem[idx], bus.d, bus.byte_write_enable_n);
                    end
                    if (c == WR_LAST_EDGE)
                    begin
                        next_st.wr_v[i] = 1'b0;
                    end
                end
            end
            for (int i = 0; i < 2; i++)
            begin
                if (st.rd_v[i])
                begin
                    c = st.rd_c[i] + 4'h1;
                    next_st.rd_c[i] = c;
                    // beats on edges five to eight
                    if ((c >= RD_FIRST_EDGE) && (c <= RD_LAST_EDGE))
                    begin
                        // burst counter walks the four words
                        idx = word_index(st.rd_a[i], c - RD_FIRST_EDGE);
                        // read after the write merge, so a pending write forwards
                        next_st.q = next_st.mem[idx];
                        next_st.q_oe = 1'b1;
                        next_st.rd_valid = 1'b1;
                    end
                    if (c == RD_LAST_EDGE)
                    begin
                        next_st.rd_v[i] = 1'b0;
                    end
                end
            end
        end

        // commands only on true clock rise; second cycle of a burst ignores them
        if (k_rise)
        begin
            if (st.cmd_busy)
            begin
                next_st.cmd_busy = 1'b0;
            end
            else if (!bus.rd_n)
            begin
                next_st.rd_v[st.rd_sel] = 1'b1;
                next_st.rd_a[st.rd_sel] = bus.addr;
                next_st.rd_c[st.rd_sel] = 4'h0;
                next_st.rd_sel = ~st.rd_sel;
                next_st.cmd_busy = 1'b1;
            end
            else if (!bus.wr_n)
            begin
                next_st.wr_v[st.wr_sel] = 1'b1;
                next_st.wr_a[st.wr_sel] = bus.addr;
                next_st.wr_c[st.wr_sel] = 4'h0;
                next_st.wr_sel = ~st.wr_sel;
                next_st.cmd_busy = 1'b1;
            end
        end
    end

    // memory clears at reset too; costs area, keeps the model deterministic
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st <= '0;
            // complement clock idles high, so no false edge after reset
            st.kn_prev <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bus.q = st.q;
    assign bus.q_oe = st.q_oe;
    assign bus.read_data_valid = st.rd_valid;
    assign bus.echo_clock = st.echo_clk;
    assign bus.echo_clock_complement = st.echo_clk_n;
    assign o_dll_locked = (st.lock_cnt == LOCK_MAX);

endmodule // burst4_sram_device
`default_nettype wire

// ==== verilog/burst4_sram_pkg.sv ====
/*
 package for the burst-of-four double-data-rate sram port and its controller.
 assumes a single 125 mhz system clock; one system cycle is one half of the
 modelled input clock pair, so the true and complementary clocks rise on
 alternate system cycles.
*/
`default_nettype none
package burst4_sram_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BURST_LEN = 4;
    localparam int BYTE_W = 9;
    // dll timing
    localparam int DLL_LOCK_TIME_CYCLES = 2048;
    localparam int STATIC_CLOCK_DLL_RESET_TIME_NS = 30;
    localparam int DLL_OFF_LOW_RESET_TIME_NS = 5;
    // least times round up, never below one cycle
    localparam int STATIC_CYCLES_RAW = (STATIC_CLOCK_DLL_RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STATIC_CYCLES = (STATIC_CYCLES_RAW < 1) ? 1 : STATIC_CYCLES_RAW;
    localparam int DOFF_CYCLES_RAW = (DLL_OFF_LOW_RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DOFF_CYCLES = (DOFF_CYCLES_RAW < 1) ? 1 : DOFF_CYCLES_RAW;
    localparam int LOCK_CNT_W = 12;
    localparam int SMALL_CNT_W = 4;
    // burst schedule, in clock edges (half cycles) after the command edge
    localparam logic [3:0] WR_FIRST_EDGE = 4'h2;
    localparam logic [3:0] WR_LAST_EDGE = 4'h5;
    localparam logic [3:0] RD_FIRST_EDGE = 4'h5;
    localparam logic [3:0] RD_LAST_EDGE = 4'h8;
    // a burst holds the address port for two full cycles
    localparam logic [3:0] CMD_GAP_EDGES = 4'h3;
    localparam logic [3:0] EDGE_SAT = 4'hf;
endpackage
`default_nettype wire

// ==== verilog/burst4_sram_if.sv ====
/*
 pin bundle between the memory controller and the sram port.
 assumes both ends run on the same system clock; the read data bus is modelled
 as value plus output enable, the bench resolves the wire level.
*/
`timescale 1ns/1ps
`default_nettype none
interface burst4_sram_if #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 36
);
    localparam int NBYTE = DATA_W / 9;
    logic k;
    logic k_n;
    logic doff_n;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic [NBYTE-1:0] byte_write_enable_n;
    logic [DATA_W-1:0] q;
    logic q_oe;
    logic echo_clock;
    logic echo_clock_complement;
    logic read_data_valid;
    modport dev (
        input k, k_n, doff_n, rd_n, wr_n, addr, d, byte_write_enable_n,
        output q, q_oe, echo_clock, echo_clock_complement, read_data_valid
    );
    modport ctl (
        output k, k_n, doff_n, rd_n, wr_n, addr, d, byte_write_enable_n,
        input q, q_oe, echo_clock, echo_clock_complement, read_data_valid
    );
endinterface
`default_nettype wire

// ==== verilog/burst4_sram_controller.sv ====
/*
 memory controller end: makes the input clock pair from the system clock,
 issues read and write bursts and collects returning read beats.
 assumes the sram end shares the system clock and the pin bundle.
*/
`timescale 1ns/1ps
`default_nettype none
module burst4_sram_controller
    import burst4_sram_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 36
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    burst4_sram_if.ctl bus,
    input wire logic i_clk_stop,
    input wire logic i_dll_reset,
    input wire logic i_rd_req,
    input wire logic i_wr_req,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [BURST_LEN*DATA_W-1:0] i_wdata,
    input wire logic [BURST_LEN*(DATA_W/BYTE_W)-1:0] i_wbe_n,
    output logic o_cmd_ready,
    output logic o_dll_locked,
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data
);
    localparam int NBYTE = DATA_W / BYTE_W;
    localparam logic [LOCK_CNT_W-1:0] LOCK_MAX = LOCK_CNT_W'(DLL_LOCK_TIME_CYCLES);
    localparam logic [SMALL_CNT_W-1:0] STATIC_MAX = SMALL_CNT_W'(STATIC_CYCLES);
    localparam logic [SMALL_CNT_W-1:0] DOFF_LEN = SMALL_CNT_W'(DOFF_CYCLES);

    typedef struct packed {
        logic k;
        logic k_n;
        logic doff_n;
        logic rd_n;
        logic wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] d;
        logic [NBYTE-1:0] bw_n;
        logic [SMALL_CNT_W-1:0] stop_cnt;
        logic [SMALL_CNT_W-1:0] doff_cnt;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic [3:0] gap;
        logic wr_busy;
        logic [3:0] wr_c;
        logic [BURST_LEN-1:0][DATA_W-1:0] wbuf;
        logic [BURST_LEN-1:0][NBYTE-1:0] bbuf;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
    } ctl_state_s;

    ctl_state_s st;
    ctl_state_s next_st;
    logic running;
    logic locked;
    logic cmd_ok;

    always_comb
    begin
        logic [3:0] c;
        c = 4'h0;
        next_st = st;
        running = ~i_clk_stop;
        locked = (st.lock_cnt == LOCK_MAX);
        // next edge must be a true clock rise, away from the last burst
        cmd_ok = locked && running && !st.k && (st.gap >= CMD_GAP_EDGES) && !st.wr_busy;
        next_st.rd_n = 1'b1;
        next_st.wr_n = 1'b1;
        next_st.bw_n = '1;

        if (i_dll_reset)
        begin
            next_st.doff_cnt = DOFF_LEN;
        end
        else if (st.doff_cnt != '0)
        begin
            next_st.doff_cnt = st.doff_cnt - SMALL_CNT_W'(1);
        end
        // dll off held low for the minimum time
        next_st.doff_n = (next_st.doff_cnt == '0);

        if (running)
        begin
            next_st.k = ~st.k;
            next_st.k_n = st.k;
            // counts cycles k has held, this one included
            next_st.stop_cnt = SMALL_CNT_W'(1);
            if (st.gap != EDGE_SAT)
            begin
                next_st.gap = st.gap + 4'h1;
            end
            if (st.wr_busy)
            begin
                c = st.wr_c + 4'h1;
                next_st.wr_c = c;
                // beats follow one cycle after the command
                if ((c >= WR_FIRST_EDGE) && (c <= WR_LAST_EDGE))
                begin
                    // enables travel with their own beat
                    next_st.d = st.wbuf[c[1:0] - WR_FIRST_EDGE[1:0]];
                    next_st.bw_n = st.bbuf[c[1:0] - WR_FIRST_EDGE[1:0]];
                end
                if (c == WR_LAST_EDGE)
                begin
                    next_st.wr_busy = 1'b0;
                end
            end
        end
        else if (st.stop_cnt != STATIC_MAX)
        begin
            next_st.stop_cnt = st.stop_cnt + SMALL_CNT_W'(1);
        end

        // wait the full lock time after any dll reset
        if ((next_st.stop_cnt == STATIC_MAX) || !st.doff_n)
        begin
            next_st.lock_cnt = '0;
        end
        else if (running && !st.k && (st.lock_cnt != LOCK_MAX))
        begin
            next_st.lock_cnt = st.lock_cnt + LOCK_CNT_W'(1);
        end

        // active-low selects, read wins a tie
        if (cmd_ok && (i_rd_req || i_wr_req))
        begin
            next_st.addr = i_addr;
            next_st.gap = 4'h0;
            if (i_rd_req)
            begin
                next_st.rd_n = 1'b0;
            end
            else
            begin
                // one address, all four beats buffered
                next_st.wr_n = 1'b0;
                next_st.wr_busy = 1'b1;
                next_st.wr_c = 4'h0;
                next_st.wbuf = i_wdata;
                next_st.bbuf = i_wbe_n;
            end
        end

        next_st.rd_valid = bus.read_data_valid & bus.q_oe;
        next_st.rd_data = bus.q;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.k_n <= 1'b1;
            st.doff_n <= 1'b1;
            st.rd_n <= 1'b1;
            st.wr_n <= 1'b1;
            st.bw_n <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign bus.k = st.k;
    assign bus.k_n = st.k_n;
    assign bus.doff_n = st.doff_n;
    assign bus.rd_n = st.rd_n;
    assign bus.wr_n = st.wr_n;
    assign bus.addr = st.addr;
    assign bus.d = st.d;
    assign bus.byte_write_enable_n = st.bw_n;
    assign o_cmd_ready = cmd_ok;
    assign o_dll_locked = locked;
    assign o_rd_valid = st.rd_valid;
    assign o_rd_data = st.rd_data;

endmodule // burst4_sram_controller
`default_nettype wire

// ==== tb/burst4_sram_chk.sv ====
/*
 checker on the pin bundle between the controller and the sram port.
 assumes the bench instantiates it beside the bundle on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module burst4_sram_chk #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 36
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic k,
    input wire logic k_n,
    input wire logic doff_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [DATA_W/9-1:0] byte_write_enable_n,
    input wire logic q_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_complement,
    input wire logic read_data_valid
);
    typedef struct packed {
        logic k_q;
        logic [8:0] rd_hist;
        logic [5:0] wr_hist;
    } hist_s;
    hist_s st;
    hist_s next_st;
    logic rise;
    logic rd_cmd;
    logic wr_cmd;
    assign rise = k && !st.k_q;
    assign rd_cmd = rise && !rd_n;
    assign wr_cmd = rise && !wr_n && rd_n;
    always_comb
    begin
        next_st.k_q = k;
        next_st.rd_hist = {st.rd_hist[7:0], rd_cmd};
        next_st.wr_hist = {st.wr_hist[4:0], wr_cmd};
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st <= '0;
        else
            st <= next_st;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    read_beats_a: assert property (rd_cmd |-> ##6 read_data_valid [*4])
        else $error("read burst not four beats at latency");
    float_idle_a: assert property (q_oe |-> (st.rd_hist[8:5] != 4'h0))
        else $error("read data driven outside a burst");
    valid_oe_a: assert property (read_data_valid == q_oe)
        else $error("valid flag differs from output enable");
    echo_clock_a: assert property (!$past(i_rst) |-> echo_clock == $past(k) && echo_clock_complement == $past(k_n))
        else $error("echo clocks do not follow the input clocks");
    byte_window_a: assert property (!(&byte_write_enable_n) |-> (st.wr_hist[4:1] != 4'h0))
        else $error("byte enable active outside write beats");
    select_rise_a: assert property ((!rd_n || !wr_n) |-> rise)
        else $error("select low off a k rise");
    cmd_spacing_a: assert property ((rd_cmd || wr_cmd) |=> (rd_n && wr_n) [*3])
        else $error("command inside a running burst");
    clock_pair_a: assert property ($changed(k) |-> k_n != k)
        else $error("complement clock not opposite");
    dll_off_pulse_a: assert property ($fell(doff_n) |=> doff_n)
        else $error("dll off pulse not one cycle");
    cover property (rd_cmd);
    cover property (wr_cmd);
    cover property (rd_cmd && st.wr_hist != 6'h00);
    cover property ($fell(doff_n));
endmodule // burst4_sram_chk
`default_nettype wire

// ==== tb/tb.sv ====
/*
 self-checking bench: controller and sram port joined by the pin bundle.
 assumes the package lock count and a 125 mhz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
    import burst4_sram_pkg::*;
;
    localparam int AW = 4;
    localparam int DW = 36;
    localparam int NB = DW / BYTE_W;
    typedef struct packed {
        logic rd;
        logic [AW-1:0] addr;
        logic [7:0] s;
        logic [BURST_LEN*NB-1:0] wbe_n;
    } row_s;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic clk_stop = 1'b0;
    logic dll_reset = 1'b0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic tie = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [BURST_LEN*DW-1:0] wdata = '0;
    logic [BURST_LEN*NB-1:0] wbe_n = '1;
    logic cmd_ready;
    logic ctl_locked;
    logic dev_locked;
    logic rd_valid;
    logic [DW-1:0] rd_data;
    logic [DW-1:0] mem [0:63];
    logic [DW-1:0] exp_q [$];
    logic [DW-1:0] exp2_q [$];
    row_s rows [9];
    int n_mismatch = 0;
    int comparisons = 0;
    always #4 i_clk = ~i_clk;
    burst4_sram_if #(.ADDR_W(AW), .DATA_W(DW)) bus ();
    burst4_sram_controller #(.ADDR_W(AW), .DATA_W(DW)) i_burst4_sram_controller (
        .i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_clk_stop(clk_stop), .i_dll_reset(dll_reset),
        .i_rd_req(rd_req), .i_wr_req(wr_req), .i_addr(addr), .i_wdata(wdata), .i_wbe_n(wbe_n),
        .o_cmd_ready(cmd_ready), .o_dll_locked(ctl_locked), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    burst4_sram_device #(.ADDR_W(AW), .DATA_W(DW)) i_burst4_sram_device (
        .i_clk(i_clk), .i_rst(i_rst), .bus(bus), .o_dll_locked(dev_locked));
    burst4_sram_chk #(.ADDR_W(AW), .DATA_W(DW)) i_burst4_sram_chk (
        .i_clk(i_clk), .i_rst(i_rst), .k(bus.k), .k_n(bus.k_n), .doff_n(bus.doff_n), .rd_n(bus.rd_n),
        .wr_n(bus.wr_n), .byte_write_enable_n(bus.byte_write_enable_n), .q_oe(bus.q_oe),
        .echo_clock(bus.echo_clock), .echo_clock_complement(bus.echo_clock_complement),
        .read_data_valid(bus.read_data_valid));
    task automatic chk_word(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // byte b of beat n carries its own index
    function automatic logic [BURST_LEN*DW-1:0] pattern(input logic [7:0] s);
        logic [BURST_LEN*DW-1:0] v;
        for (int n = 0; n < BURST_LEN * NB; n++)
            v[n*BYTE_W +: BYTE_W] = {s[4:0], n[3:0]};
        return v;
    endfunction
    task automatic issue(input row_s r);
        int i;
        logic [BURST_LEN*DW-1:0] v;
        i = 0;
        v = pattern(r.s);
        while (cmd_ready !== 1'b1 && i < 6000)
        begin
            @(negedge i_clk);
            i++;
        end
        rd_req = r.rd;
        wr_req = !r.rd || tie;
        addr = r.addr;
        wdata = v;
        wbe_n = r.wbe_n;
        for (int n = 0; n < BURST_LEN; n++)
            for (int b = 0; b < NB; b++)
                if (!r.rd && !r.wbe_n[n*NB+b])
                    mem[{r.addr, n[1:0]}][b*BYTE_W +: BYTE_W] = v[n*DW+b*BYTE_W +: BYTE_W];
        for (int n = 0; n < BURST_LEN; n++)
            if (r.rd)
                exp_q.push_back(mem[{r.addr, n[1:0]}]);
        @(negedge i_clk);
        rd_req = 1'b0;
        wr_req = 1'b0;
    endtask
    task automatic wait_lock(output int cnt);
        cnt = 0;
        while (cmd_ready !== 1'b1 && cnt < 6000)
        begin
            @(negedge i_clk);
            cnt++;
        end
        chk_bit("dev_locked", 1'b1, dev_locked);
    endtask
    always @(negedge i_clk)
    begin
        if (bus.read_data_valid === 1'b1 && exp_q.size() > 0)
        begin
            chk_word("q", exp_q[0], bus.q);
            exp2_q.push_back(exp_q.pop_front());
        end
        if (rd_valid === 1'b1 && exp2_q.size() > 0)
            chk_word("rd_data", exp2_q.pop_front(), rd_data);
    end
    initial
    begin
        repeat (30000) @(posedge i_clk);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        int cnt;
        for (int j = 0; j < 64; j++)
            mem[j] = '0;
        rows = '{'{1'b0, 4'h0, 8'h01, 16'h0000}, '{1'b0, 4'hf, 8'h02, 16'h0000}, '{1'b1, 4'h0, 8'h00, 16'hffff},
            '{1'b1, 4'hf, 8'h00, 16'hffff}, '{1'b0, 4'h5, 8'h03, 16'ha5c3}, '{1'b1, 4'h5, 8'h00, 16'hffff},
            '{1'b0, 4'h5, 8'h04, 16'hffff}, '{1'b1, 4'h5, 8'h00, 16'hffff}, '{1'b1, 4'h7, 8'h00, 16'hffff}};
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        wait_lock(cnt);
        chk_bit("lock_wait", 1'b1, cnt >= 2 * DLL_LOCK_TIME_CYCLES - 1);
        foreach (rows[j])
            issue(rows[j]);
        tie = 1'b1;
        issue(rows[8]);
        tie = 1'b0;
        repeat (20) @(negedge i_clk);
        chk_bit("q_oe", 1'b0, bus.q_oe);
        chk_bit("drained", 1'b1, exp_q.size() == 0 && exp2_q.size() == 0);
        // short stop stays under the static limit
        clk_stop = 1'b1;
        repeat (2) @(negedge i_clk);
        clk_stop = 1'b0;
        repeat (4) @(negedge i_clk);
        chk_bit("dev_locked", 1'b1, dev_locked);
        chk_bit("ctl_locked", 1'b1, ctl_locked);
        dll_reset = 1'b1;
        @(negedge i_clk);
        dll_reset = 1'b0;
        repeat (4) @(negedge i_clk);
        chk_bit("dev_locked", 1'b0, dev_locked);
        chk_bit("cmd_ready", 1'b0, cmd_ready);
        wait_lock(cnt);
        clk_stop = 1'b1;
        // shortest stop that reaches the static limit
        repeat (3) @(negedge i_clk);
        clk_stop = 1'b0;
        @(negedge i_clk);
        chk_bit("dev_locked", 1'b0, dev_locked);
        chk_bit("ctl_locked", 1'b0, ctl_locked);
        wait_lock(cnt);
        issue(rows[3]);
        repeat (20) @(negedge i_clk);
        chk_bit("drained", 1'b1, exp_q.size() == 0 && exp2_q.size() == 0);
        summarize();
    end
endmodule // tb
`default_nettype wire
